//--- core/reload_capture_timer_core.sv
/*
 * counting core and mode selection of a 16-bit timer/counter with one
 * 16-bit reload/capture register; assumes all inputs synchronous to clk_sys
 */
// What this block does
// RQ1: sixteen-bit counter, increments each clock unprescaled
// RQ2: select bit picks clocks or external events
// RQ3: compatibility mode prescales outside baud and frequency modes, default divide six
// RQ4: compatibility rate-halving bit halves count rate
// RQ5: fast mode bypasses prescaler unless halving set
// RQ6: baud and frequency modes skip prescaler
// RQ7: fast counter samples pin, counts high-low
// RQ8: counted value visible cycle after detection
// RQ9: source holds each level one clock
// RQ10: compatibility samples pin at prescaler rate
// RQ11: mode precedence: off, freq, baud, capture/reload
// RQ12: capture or reload up, up-down with enable
// RQ13: min 0000H, max FFFFH, bottom reload value
// RQ14: direction input and external reload/capture trigger
// RQ15: toggle output pin on overflow, freq mode
// RQ16: external-event flag set on trigger, software clears
// RQ17: no event interrupt in up-down mode
// RQ18: reset clears counter, reload register, flags, output, mode
// RQ19: run clear holds counter value
`timescale 1ns/10ps
module reload_capture_timer_core
    import reload_capture_timer_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // software control and writes
    input  wire timer_ctrl_s        ctrl,
    input  wire timer_write_s       wr,
    // external pins
    input  wire logic               extCountPin,
    input  wire logic               extReloadCaptureInput,
    input  wire logic               countDirection,
    // state seen by software
    output logic [CNT_W-1:0]        count,
    output logic [CNT_W-1:0]        reloadCapture,
    output logic                    overflowFlag,
    output logic                    extEventFlag,
    output logic                    extEventIrq,
    output logic                    toggleOut,
    output timer_mode_e             mode
);
    // prescaler position and halving phase
    logic [PS_W-1:0]  psCount;
    logic             halfPhase;
    // last sampled levels of count pin and trigger input; both reset low
    // so that a pin held low through reset cannot fake a falling edge after reset
    logic             pinSample;
    logic             trigSample;
    // counter value for the next clock
    logic [CNT_W-1:0] next_count;

    // mode decode in precedence order
    wire timer_mode_e next_mode =
        !ctrl.runControlBit ? MODE_OFF :                        // RQ11
        ctrl.toggleOutputEnable ? MODE_FREQ_GEN :
        (ctrl.txBaudClockSelect || ctrl.rxBaudClockSelect) ? MODE_BAUD_GEN :
        ctrl.captureNotReload ? MODE_CAPTURE :                  // RQ12
        ctrl.downCountEnable ? MODE_RELOAD_UPDOWN : MODE_RELOAD_UP;

    // prescaler: divide by prescale value plus one, optionally doubled
    wire noPrescale  = (next_mode == MODE_FREQ_GEN) || (next_mode == MODE_BAUD_GEN) // RQ6
                     || (ctrl.fastMode && !ctrl.rateHalvingBit);                    // RQ5
    wire psWrap      = (psCount[PS_W-1:0] >= ctrl.prescaleValue);                   // RQ3
    wire halveNeeded = !ctrl.fastMode && ctrl.rateHalvingBit;                       // RQ4
    wire rateTick    = noPrescale ? 1'b1 : (psWrap && (!halveNeeded || halfPhase));

    // counter input: clock tick or sampled falling edge of count pin
    wire sampleNow   = ctrl.fastMode ? 1'b1 : rateTick;                             // RQ10
    wire fallSeen    = sampleNow && pinSample && !extCountPin;                      // RQ7
    wire countStep   = ctrl.timerOrCounterSelect ? fallSeen : rateTick;             // RQ2
    wire running     = (next_mode != MODE_OFF);                                     // RQ19

    // external trigger edge and direction
    wire trigFall    = trigSample && !extReloadCaptureInput && ctrl.extInputEnable; // RQ14
    wire upDown      = (next_mode == MODE_RELOAD_UPDOWN);
    wire goDown      = upDown && !countDirection;
    wire atTop       = (count == COUNT_MAX);                                        // RQ13
    wire atBottom    = (count == reloadCapture);
    wire overflow    = running && countStep && (goDown ? atBottom : atTop);
    wire reloadNow   = (next_mode == MODE_RELOAD_UP) || (next_mode == MODE_BAUD_GEN)
                     || (next_mode == MODE_FREQ_GEN);
    wire trigAct     = running && trigFall && (next_mode == MODE_CAPTURE
                     || next_mode == MODE_RELOAD_UP);                               // RQ16

    // next counter value
    always_comb
    begin
        next_count = count;
        // a software write beats every other source
        if (wr.countWrite)
            next_count = wr.countData;
        else if (trigAct && next_mode == MODE_RELOAD_UP)
            next_count = reloadCapture;
        else if (running && countStep)                                              // RQ1
        begin
            // down count wraps from bottom to the top value
            if (goDown)
                next_count = atBottom ? COUNT_MAX : count - 16'h0001;
            // up count reloads bottom at the top value, capture mode rolls to zero
            else if (atTop && (reloadNow || upDown))
                next_count = reloadCapture;
            else
                next_count = count + 16'h0001;                                      // RQ8
        end
    end

    // prescaler and input samplers
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            psCount    <= '0;
            halfPhase  <= 1'b0;
            pinSample  <= 1'b0;
            trigSample <= 1'b0;
        end
        else
        begin
            psCount    <= psWrap ? '0 : psCount + 1'b1;
            halfPhase  <= psWrap ? !halfPhase : halfPhase;
            pinSample  <= sampleNow ? extCountPin : pinSample;
            trigSample <= extReloadCaptureInput;
        end
    end

    // counter, reload/capture register, flags and output
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)                                                                  // RQ18
        begin
            count         <= COUNT_RST;
            reloadCapture <= RELOAD_RST;
            overflowFlag  <= 1'b0;
            extEventFlag  <= 1'b0;
            extEventIrq   <= 1'b0;
            toggleOut     <= 1'b0;
            mode          <= MODE_OFF;
        end
        else
        begin
            count         <= next_count;
            mode          <= next_mode;
            if (wr.reloadWrite)
                reloadCapture <= wr.reloadData;
            else if (trigAct && next_mode == MODE_CAPTURE)
                reloadCapture <= count;
            // set wins over clear
            overflowFlag  <= (overflow && next_mode != MODE_BAUD_GEN)
                             || (overflowFlag && !wr.flagClear);
            extEventFlag  <= trigAct || (extEventFlag && !wr.extFlagClear);        // RQ16
            extEventIrq   <= (trigAct || (extEventFlag && !wr.extFlagClear)) && !upDown; // RQ17
            if (overflow && next_mode == MODE_FREQ_GEN)                             // RQ15
                toggleOut <= !toggleOut;
        end
    end

    // checks, gathered after all of the logic that they guard

    // reset leaves counter and mode cleared
    reset_state_a: assert property (@(posedge clk_sys) !nrst |=> count == COUNT_RST
        && mode == MODE_OFF) else $error("reset state wrong"); // RQ18

    // reset also clears reload register, flags and output pin
    reset_outs_a: assert property (@(posedge clk_sys) !nrst |=> reloadCapture == RELOAD_RST
        && !overflowFlag && !extEventFlag && !extEventIrq && !toggleOut) // RQ18
        else $error("reset outputs wrong");

    // an idle timer keeps its value
    hold_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (next_mode == MODE_OFF && !wr.countWrite) |=> $stable(count))
        else $error("counter moved while off"); // RQ19

    // software writes land whatever the mode
    // so a stopped timer can still be preset
    count_write_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ19
        wr.countWrite |=> count == $past(wr.countData))
        else $error("count write lost");

    // unprescaled timer steps every clock
    fast_timer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (next_mode == MODE_RELOAD_UP && ctrl.fastMode && !ctrl.rateHalvingBit
        && !ctrl.timerOrCounterSelect && !wr.countWrite && !trigAct && !atTop)
        |=> count == $past(count) + 16'h0001) else $error("fast timer step"); // RQ1

    // no tick and no event means no step
    // whichever source the select bit picks
    no_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ2
        (running && !countStep && !wr.countWrite && !trigAct) |=> $stable(count))
        else $error("step without tick");

    // a detected falling edge shows up one clock later
    edge_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ctrl.timerOrCounterSelect && ctrl.fastMode && next_mode == MODE_RELOAD_UP
        && pinSample && !extCountPin && !wr.countWrite && !trigAct && !atTop)
        |=> count == $past(count) + 16'h0001) else $error("edge not counted"); // RQ8

    // two edges cannot be seen in adjacent clocks,
    // which caps the count rate at half the clock
    max_rate_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ7
        (fallSeen && ctrl.fastMode) |=> !fallSeen)
        else $error("edge rate too high");

    // down counting steps by one above bottom
    // in up-down mode the direction pin chooses the way
    down_step_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ14
        (running && countStep && goDown && !atBottom && !wr.countWrite)
        |=> count == $past(count) - 16'h0001) else $error("down step wrong");

    // down counting at bottom wraps to the top value
    // and reports an overflow
    down_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
        (running && countStep && goDown && atBottom && !wr.countWrite)
        |=> count == COUNT_MAX) else $error("down wrap wrong");

    // reloading modes restart from bottom at the top value
    // instead of rolling to zero
    reload_wrap_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
        (running && countStep && !goDown && atTop && reloadNow && !wr.countWrite
        && !trigAct) |=> count == $past(reloadCapture)) else $error("reload wrap wrong");

    // trigger edge reloads the counter in reload-up mode
    // a count write on the same clock still wins
    trig_reload_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ14
        (trigAct && next_mode == MODE_RELOAD_UP && !wr.countWrite)
        |=> count == $past(reloadCapture)) else $error("trigger reload lost");

    // trigger edge latches the count in capture mode
    // a reload write on the same clock still wins
    capture_load_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ16
        (trigAct && next_mode == MODE_CAPTURE && !wr.reloadWrite)
        |=> reloadCapture == $past(count)) else $error("capture lost");

    // output pin flips on each overflow in frequency mode
    freq_toggle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (overflow && next_mode == MODE_FREQ_GEN) |=> toggleOut != $past(toggleOut))
        else $error("no toggle on overflow"); // RQ15

    // without such an overflow the pin keeps its level
    // so software sees a clean square wave
    no_toggle_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ15
        !(overflow && next_mode == MODE_FREQ_GEN) |=> $stable(toggleOut))
        else $error("stray toggle");

    // an overflow outside baud mode raises the flag
    // so that a clear on the same clock loses
    ovf_set_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
        (overflow && next_mode != MODE_BAUD_GEN) |=> overflowFlag)
        else $error("overflow flag missed");

    // a clear with no overflow drops the flag
    // software alone takes it down
    ovf_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ13
        (wr.flagClear && !overflow) |=> !overflowFlag)
        else $error("overflow flag stuck");

    // an accepted trigger raises the event flag
    ext_flag_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        trigAct |=> extEventFlag) else $error("event flag missed"); // RQ16

    // a clear with no trigger drops the event flag
    // set wins when both fall in one clock
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ16
        (wr.extFlagClear && !trigAct) |=> !extEventFlag)
        else $error("event flag stuck");

    // with the trigger input disabled the flag cannot rise
    // whatever the trigger pin does
    flag_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ16
        (!ctrl.extInputEnable && !extEventFlag) |=> !extEventFlag)
        else $error("event flag without enable");

    // up-down counting never raises the event irq
    updown_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        upDown |=> !extEventIrq) else $error("irq in up-down"); // RQ17

    // run bit clear forces the off mode
    // before any other select bit is looked at
    off_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ11
        !ctrl.runControlBit |=> mode == MODE_OFF)
        else $error("off precedence");

    // toggle enable outranks everything but run
    mode_prec_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ctrl.runControlBit && ctrl.toggleOutputEnable) |=> mode == MODE_FREQ_GEN)
        else $error("mode precedence"); // RQ11

    // either baud select outranks capture and reload
    // when the toggle output is off
    baud_prec_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ11
        (ctrl.runControlBit && !ctrl.toggleOutputEnable && (ctrl.txBaudClockSelect
        || ctrl.rxBaudClockSelect)) |=> mode == MODE_BAUD_GEN) else $error("baud precedence");

    // capture bit picks capture mode
    // with no baud select and no toggle output
    capture_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ12
        (ctrl.runControlBit && !ctrl.toggleOutputEnable && !ctrl.txBaudClockSelect
        && !ctrl.rxBaudClockSelect && ctrl.captureNotReload) |=> mode == MODE_CAPTURE)
        else $error("capture mode");

    // down enable picks up-down reload
    // when capture is not selected
    updown_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ12
        (ctrl.runControlBit && !ctrl.toggleOutputEnable && !ctrl.txBaudClockSelect
        && !ctrl.rxBaudClockSelect && !ctrl.captureNotReload && ctrl.downCountEnable)
        |=> mode == MODE_RELOAD_UPDOWN) else $error("up-down mode");

    // plain reload counts up only
    // when neither capture nor down enable is set
    reload_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RQ12
        (ctrl.runControlBit && !ctrl.toggleOutputEnable && !ctrl.txBaudClockSelect
        && !ctrl.rxBaudClockSelect && !ctrl.captureNotReload && !ctrl.downCountEnable)
        |=> mode == MODE_RELOAD_UP) else $error("reload mode");
endmodule

//--- core/reload_capture_timer_pkg.sv
/*
 * constants, mode enumeration and port structs for the reload/capture timer core
 * assumes one system clock; all control bits arrive packed in the timer_ctrl_s port struct
 */
package reload_capture_timer_pkg;
    localparam int          CNT_W          = 16;
    localparam int          PS_W           = 4;
    localparam logic [15:0] COUNT_MIN      = 16'h0000;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] RELOAD_RST     = 16'h0000;
    localparam logic [3:0]  PRESCALE_RST   = 4'h5;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_FREQ_GEN,
        MODE_BAUD_GEN,
        MODE_CAPTURE,
        MODE_RELOAD_UP,
        MODE_RELOAD_UPDOWN
    } timer_mode_e;

    // software-side control bits
    typedef struct packed {
        logic       runControlBit;
        logic       timerOrCounterSelect;
        logic       captureNotReload;
        logic       downCountEnable;
        logic       toggleOutputEnable;
        logic       txBaudClockSelect;
        logic       rxBaudClockSelect;
        logic       extInputEnable;
        logic       rateHalvingBit;
        logic       fastMode;
        logic [3:0] prescaleValue;
    } timer_ctrl_s;

    // software writes to counter and reload/capture register
    typedef struct packed {
        logic        countWrite;
        logic [15:0] countData;
        logic        reloadWrite;
        logic [15:0] reloadData;
        logic        flagClear;
        logic        extFlagClear;
    } timer_write_s;
endpackage

//--- test/ext_event_source.sv
/*
 * model of the external event source on the count pin
 * assumes the bench calls its task and shares clk_sys
 */
`timescale 1ns/10ps
module ext_event_source
(
    // clock
    input  wire logic clk_sys,
    // count pin, idles high like a pulled-up port
    output logic      extCountPin
);
    initial extCountPin = 1'b1;

    // n falling edges, each level held for hold clocks
    task automatic pulses(input int n, input int hold);
        repeat (n)
        begin
            repeat (hold) @(negedge clk_sys);
            extCountPin = 1'b0;
            repeat (hold) @(negedge clk_sys);
            extCountPin = 1'b1;
        end
    endtask
endmodule

//--- test/tb_top.sv
/*
 * self-checking bench for the timer core
 * assumes the package and the event source model
 */
`timescale 1ns/10ps
module tb_top import reload_capture_timer_pkg::*;;
    logic         clk_sys, nrst, extRc, countDirection, extCountPin;
    timer_ctrl_s  ctrl;
    timer_write_s wr;
    logic [15:0]  count, reloadCapture, c0;
    logic         overflowFlag, extEventFlag, extEventIrq, toggleOut;
    timer_mode_e  mode;
    int           num_errors, comparisons;
    logic [4:0]   mIn [6] = '{5'h00, 5'h1F, 5'h17, 5'h13, 5'h10, 5'h11};
    timer_mode_e  mExp [6] = '{MODE_OFF, MODE_FREQ_GEN, MODE_BAUD_GEN,
                               MODE_CAPTURE, MODE_RELOAD_UP, MODE_RELOAD_UPDOWN};

    reload_capture_timer_core reload_capture_timer_core_i (.clk_sys(clk_sys),
        .nrst(nrst), .ctrl(ctrl), .wr(wr), .extCountPin(extCountPin),
        .extReloadCaptureInput(extRc), .countDirection(countDirection),
        .count(count), .reloadCapture(reloadCapture), .overflowFlag(overflowFlag),
        .extEventFlag(extEventFlag), .extEventIrq(extEventIrq),
        .toggleOut(toggleOut), .mode(mode));
    ext_event_source ext_event_source_i (.clk_sys(clk_sys), .extCountPin(extCountPin));

    // 20 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            num_errors++;
    endtask

    // count advance over n clocks after settling
    task automatic span(input int n, input logic [15:0] exp);
        repeat (3) @(negedge clk_sys);
        c0 = count;
        repeat (n) @(negedge clk_sys);
        check(count - c0, exp);
    endtask

    task automatic conclude();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence, inputs change at the falling edge
    initial
    begin
        nrst = 1'b0;
        ctrl = '0;
        wr = '0;
        extRc = 1'b1;
        countDirection = 1'b1;
        num_errors = 0;
        comparisons = 0;
        ctrl.prescaleValue = PRESCALE_RST;
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        check(count, 16'h0000);
        check(16'(mode), 16'(MODE_OFF));
        for (int i = 0; i < 6; i++)
        begin
            {ctrl.runControlBit, ctrl.toggleOutputEnable, ctrl.txBaudClockSelect,
             ctrl.captureNotReload, ctrl.downCountEnable} = mIn[i];
            repeat (3) @(negedge clk_sys);
            check(16'(mode), 16'(mExp[i]));
        end
        ctrl.downCountEnable = 1'b0;
        span(60, 16'h000A);
        ctrl.rateHalvingBit = 1'b1;
        span(60, 16'h0005);
        ctrl.fastMode = 1'b1;
        span(60, 16'h000A);
        ctrl.rateHalvingBit = 1'b0;
        span(10, 16'h000A);
        ctrl.fastMode = 1'b0;
        ctrl.txBaudClockSelect = 1'b1;
        span(10, 16'h000A);
        ctrl.txBaudClockSelect = 1'b0;
        ctrl.runControlBit = 1'b0;
        span(20, 16'h0000);
        ctrl.runControlBit = 1'b1;
        ctrl.timerOrCounterSelect = 1'b1;
        ctrl.fastMode = 1'b1;
        fork
            begin
                repeat (3) @(negedge clk_sys);
                ext_event_source_i.pulses(5, 1);
            end
            span(16, 16'h0005);
        join
        ctrl.fastMode = 1'b0;
        fork
            begin
                repeat (3) @(negedge clk_sys);
                ext_event_source_i.pulses(3, 6);
            end
            span(50, 16'h0003);
        join
        ctrl.runControlBit = 1'b0;
        ctrl.timerOrCounterSelect = 1'b0;
        ctrl.fastMode = 1'b1;
        wr.reloadWrite = 1'b1;
        wr.reloadData = 16'h1234;
        @(negedge clk_sys);
        wr.reloadWrite = 1'b0;
        wr.countWrite = 1'b1;
        wr.countData = 16'hFFFD;
        @(negedge clk_sys);
        wr.countWrite = 1'b0;
        check(reloadCapture, 16'h1234);
        ctrl.runControlBit = 1'b1;
        repeat (8) @(negedge clk_sys);
        ctrl.runControlBit = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(count, 16'h1239);
        check(16'(overflowFlag), 16'h0001);
        ctrl.runControlBit = 1'b1;
        ctrl.captureNotReload = 1'b1;
        ctrl.extInputEnable = 1'b1;
        repeat (3) @(negedge clk_sys);
        extRc = 1'b0;
        repeat (3) @(negedge clk_sys);
        check(16'(extEventFlag), 16'h0001);
        check(16'(extEventIrq), 16'h0001);
        wr.extFlagClear = 1'b1;
        @(negedge clk_sys);
        wr.extFlagClear = 1'b0;
        @(negedge clk_sys);
        check(16'(extEventFlag), 16'h0000);
        // capture trigger sets the flag, then up-down gates the irq off
        extRc = 1'b1;
        @(negedge clk_sys);
        extRc = 1'b0;
        @(negedge clk_sys);
        ctrl.captureNotReload = 1'b0;
        ctrl.downCountEnable = 1'b1;
        countDirection = 1'b0;
        wr.countWrite = 1'b1;
        wr.countData = 16'h1236;
        wr.reloadWrite = 1'b1;
        wr.reloadData = 16'h1234;
        @(negedge clk_sys);
        wr.countWrite = 1'b0;
        wr.reloadWrite = 1'b0;
        check(16'(extEventFlag), 16'h0001);
        check(16'(extEventIrq), 16'h0000);
        repeat (4) @(negedge clk_sys);
        check(count, 16'hFFFE);
        countDirection = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(count, 16'h1235);
        // frequency generator toggles its pin on overflow
        ctrl.downCountEnable = 1'b0;
        ctrl.toggleOutputEnable = 1'b1;
        wr.countWrite = 1'b1;
        wr.countData = 16'hFFFE;
        @(negedge clk_sys);
        wr.countWrite = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(16'(toggleOut), 16'h0001);
        check(count, 16'h1234);
        // baud generator reloads without raising the overflow flag
        ctrl.toggleOutputEnable = 1'b0;
        ctrl.txBaudClockSelect = 1'b1;
        wr.flagClear = 1'b1;
        wr.countWrite = 1'b1;
        wr.countData = 16'hFFFE;
        @(negedge clk_sys);
        wr.flagClear = 1'b0;
        wr.countWrite = 1'b0;
        check(16'(overflowFlag), 16'h0000);
        repeat (2) @(negedge clk_sys);
        check(16'(overflowFlag), 16'h0000);
        check(count, 16'h1234);
        conclude();
    end
endmodule
